// ### core/dct_core.sv
// What this block does
// - Counting from zero round to FFh is never flagged as a timeout.
// - Start takes effect on the next counter/timer clock after the write; stop as soon as the enable bit clears.
// - In demodulation, first selected edge after enable starts the down-count.
// - Further edge captures complemented count; rising and falling have own registers.
// - Capture sets matching edge flag; interrupt if capture enable set.
// - Capture reloads eight-bit timer with FFh and counting continues.
// - Demodulation reaching zero sets timeout, may interrupt, continues from FFh.
// - Restarting a stopped timer reloads its programmed initial value.
// - Ping-pong hardware alternates the enable bits, one timer running.
// - In ping-pong each timer sets its timeout at every terminal count.
// - Eight-bit output enable drives eight-bit timer output on port3 bit four.
// - Sixteen-bit output enable drives its timer output on port3 bit five.
// - Combined enable drives selected logic of both outputs on bit six.
// - Each timer interrupt is individually and globally maskable.
// - Timers keep counting and interrupting while the processor is halted.
`timescale 1ns/100ps
module dct_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        edge_in,
  output logic             irq,
  output logic             port3_bit_four,
  output logic             port3_bit_four_oe,
  output logic             port3_bit_five,
  output logic             port3_bit_five_oe,
  output logic             port3_bit_six,
  output logic             port3_bit_six_oe
);

  dct_pkg::dct_ctl_s c8_reg, c8_next, c16_reg, c16_next;
  dct_pkg::dct_shr_s sh_reg, sh_next;
  dct_pkg::dct_pin_s pin_reg, pin_next;
  dct_pkg::dct_dm_e  dm_reg, dm_next;
  logic [15:0] rl8_reg, rl16_reg;
  logic [7:0]  cnt8_reg, cnt8_next, pos_cap_reg, neg_cap_reg;
  logic [15:0] cnt16_reg, cnt16_next;
  logic        out8_reg, out8_next, out16_reg, out16_next;
  logic        run8_reg, run16_reg, edge_prev_reg, glob_reg;
  logic [3:0]  div_reg, ist_reg, ist_next, imask_reg;
  logic [31:0] prdata_reg, rd_mux;
  logic        err_reg;

  // Bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_c8 = paddr == dct_pkg::OFF_CTRL8;
  wire hit_sh = paddr == dct_pkg::OFF_SHARED;
  wire hit_c16 = paddr == dct_pkg::OFF_CTRL16;
  wire hit_rl8 = paddr == dct_pkg::OFF_RELOAD8;
  wire hit_rl16 = paddr == dct_pkg::OFF_RELOAD16;
  wire hit_cap = paddr == dct_pkg::OFF_CAPTURE;
  wire hit_cnt = paddr == dct_pkg::OFF_COUNT;
  wire hit_ist = paddr == dct_pkg::OFF_ISTAT;
  wire hit_im = paddr == dct_pkg::OFF_IMASK;
  wire hit_any = hit_c8 | hit_sh | hit_c16 | hit_rl8 | hit_rl16 | hit_cap
               | hit_cnt | hit_ist | hit_im;

  // Counter/timer clock enable
  wire tick = div_reg == dct_pkg::TICK_LAST;

  // Run state follows the enable bit only on a tick
  wire start8 = tick & c8_reg.en & ~run8_reg;
  wire start16 = tick & c16_reg.en & ~run16_reg;
  wire live8 = run8_reg & c8_reg.en;
  wire live16 = run16_reg & c16_reg.en;
  wire go8 = tick & live8;
  wire go16 = tick & live16;
  wire pp_on = sh_reg.pp == dct_pkg::PP_ON;

  // Edge qualification
  wire rise = edge_in & ~edge_prev_reg;
  wire fall = ~edge_in & edge_prev_reg;
  wire qual = (sh_reg.sel == dct_pkg::SEL_RISE) ? rise :
              (sh_reg.sel == dct_pkg::SEL_FALL) ? fall : (rise | fall);
  wire dm_counting = c8_reg.demod & (dm_reg == dct_pkg::DM_COUNT);
  wire cap_any = dm_counting & live8 & qual;
  wire cap_pos = cap_any & rise;
  wire cap_neg = cap_any & fall;

  // Terminal count: reaching zero from one, never the wrap from zero
  wire to8_ev = go8 & (cnt8_reg == 8'h01)
              & (~c8_reg.demod | (dm_counting & ~cap_any));
  wire to16_ev = go16 & (cnt16_reg == 16'h0001);

  wire [3:0] ev_vec = {cap_neg, cap_pos, to16_ev, to8_ev};
  wire [3:0] ie_vec = {c8_reg.cap_ie, c8_reg.cap_ie,
                       c16_reg.to_ie, c8_reg.to_ie};

  wire comb_out = (sh_reg.sel == dct_pkg::SEL_RISE) ? (out8_reg & out16_reg) :
                  (sh_reg.sel == dct_pkg::SEL_FALL) ? (out8_reg | out16_reg) :
                  (sh_reg.sel == dct_pkg::SEL_XNOR) ? ~(out8_reg ^ out16_reg) :
                  (out8_reg ^ out16_reg);

  assign rd_mux =
    hit_c8   ? {24'h00_0000, c8_reg} :
    hit_sh   ? {24'h00_0000, sh_reg} :
    hit_c16  ? {24'h00_0000, c16_reg} :
    hit_rl8  ? {16'h0000, rl8_reg} :
    hit_rl16 ? {16'h0000, rl16_reg} :
    hit_cap  ? {16'h0000, neg_cap_reg, pos_cap_reg} :
    hit_cnt  ? {cnt16_reg, 8'h00, cnt8_reg} :
    hit_ist  ? {28'h000_0000, ist_reg} :
    hit_im   ? {27'h000_0000, glob_reg, imask_reg} : 32'h0000_0000;

  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = access & err_reg;

  // Interrupt: per-source control enable, mask bit, and global enable
  assign irq = glob_reg & |(ist_reg & imask_reg & ie_vec);

  assign port3_bit_four = pin_reg.p4;
  assign port3_bit_five = pin_reg.p5;
  assign port3_bit_six = pin_reg.p6;
  assign port3_bit_four_oe = pin_reg.oe4;
  assign port3_bit_five_oe = pin_reg.oe5;
  assign port3_bit_six_oe = pin_reg.oe6;

  always_comb begin
    pin_next.p4 = c8_reg.out_en & out8_reg;
    pin_next.oe4 = c8_reg.out_en;
    pin_next.p5 = c16_reg.out_en & out16_reg;
    pin_next.oe5 = c16_reg.out_en;
    pin_next.p6 = sh_reg.comb_en & comb_out;
    pin_next.oe6 = sh_reg.comb_en;
  end

  // Eight-bit control: hardware flag set wins over write-one-clear
  always_comb begin
    c8_next = c8_reg;
    if (wr && hit_c8) begin
      c8_next = dct_pkg::dct_ctl_s'(pwdata[7:0]);
      c8_next.rsvd = 1'b0;
      c8_next.timeout = c8_reg.timeout & ~pwdata[dct_pkg::BIT_TIMEOUT];
    end
    if (to8_ev && (c8_reg.single || pp_on)) begin
      c8_next.en = 1'b0;
    end
    if (to16_ev && pp_on) begin
      c8_next.en = 1'b1;
    end
    if (to8_ev) begin
      c8_next.timeout = 1'b1;
    end
  end

  always_comb begin
    c16_next = c16_reg;
    if (wr && hit_c16) begin
      c16_next = dct_pkg::dct_ctl_s'(pwdata[7:0]);
      c16_next.rsvd = 1'b0;
      c16_next.demod = 1'b0;
      c16_next.cap_ie = 1'b0;
      c16_next.timeout = c16_reg.timeout & ~pwdata[dct_pkg::BIT_TIMEOUT];
    end
    if (to16_ev && (c16_reg.single || pp_on)) begin
      c16_next.en = 1'b0;
    end
    if (to8_ev && pp_on) begin
      c16_next.en = 1'b1;
    end
    if (to16_ev) begin
      c16_next.timeout = 1'b1;
    end
  end

  always_comb begin
    sh_next = sh_reg;
    if (wr && hit_sh) begin
      sh_next = dct_pkg::dct_shr_s'(pwdata[7:0]);
      sh_next.rsvd = 1'b0;
      sh_next.pos_flag = sh_reg.pos_flag & ~pwdata[dct_pkg::BIT_POS_FLAG];
      sh_next.neg_flag = sh_reg.neg_flag & ~pwdata[dct_pkg::BIT_NEG_FLAG];
    end
    if (cap_pos) begin
      sh_next.pos_flag = 1'b1;
    end
    if (cap_neg) begin
      sh_next.neg_flag = 1'b1;
    end
  end

  always_comb begin
    ist_next = ist_reg;
    if (wr && hit_ist) begin
      ist_next = ist_reg & ~pwdata[3:0];
    end
    ist_next = ist_next | ev_vec;
  end

  // Eight-bit timer: modulo count, or demodulation capture
  always_comb begin
    cnt8_next = cnt8_reg;
    out8_next = out8_reg;
    dm_next = dm_reg;
    if (start8) begin
      cnt8_next = rl8_reg[7:0];
      dm_next = dct_pkg::DM_WAIT;
    end else if (c8_reg.demod) begin
      unique case (dm_reg)
        dct_pkg::DM_WAIT: begin
          if (live8 && qual) begin
            dm_next = dct_pkg::DM_COUNT;
          end
        end
        dct_pkg::DM_COUNT: begin
          if (cap_any) begin
            cnt8_next = dct_pkg::ALL_ONES8;
          end else if (go8) begin
            cnt8_next = cnt8_reg - 8'h01;
          end
        end
      endcase
    end else if (go8) begin
      if (cnt8_reg <= 8'h01) begin
        cnt8_next = out8_reg ? rl8_reg[7:0] : rl8_reg[15:8];
      end else begin
        cnt8_next = cnt8_reg - 8'h01;
      end
      if (to8_ev) begin
        out8_next = ~out8_reg;
      end
    end
  end

  // Sixteen-bit timer
  always_comb begin
    cnt16_next = cnt16_reg;
    out16_next = out16_reg;
    if (start16) begin
      cnt16_next = rl16_reg;
    end else if (go16) begin
      if (cnt16_reg <= 16'h0001) begin
        cnt16_next = rl16_reg;
      end else begin
        cnt16_next = cnt16_reg - 16'h0001;
      end
      if (to16_ev) begin
        out16_next = ~out16_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 4'h0;
      run8_reg <= 1'b0;
      run16_reg <= 1'b0;
      edge_prev_reg <= 1'b0;
    end else begin
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
      if (tick) begin
        run8_reg <= c8_reg.en;
        run16_reg <= c16_reg.en;
      end
      edge_prev_reg <= edge_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c8_reg <= dct_pkg::dct_ctl_s'(dct_pkg::RST_CTRL);
      c16_reg <= dct_pkg::dct_ctl_s'(dct_pkg::RST_CTRL);
      sh_reg <= dct_pkg::dct_shr_s'(dct_pkg::RST_CTRL);
      ist_reg <= dct_pkg::RST_IRQ;
      imask_reg <= dct_pkg::RST_IRQ;
      glob_reg <= 1'b0;
      rl8_reg <= dct_pkg::RST_RELOAD;
      rl16_reg <= dct_pkg::RST_RELOAD;
    end else begin
      c8_reg <= c8_next;
      c16_reg <= c16_next;
      sh_reg <= sh_next;
      ist_reg <= ist_next;
      if (wr && hit_im) begin
        imask_reg <= pwdata[3:0];
        glob_reg <= pwdata[dct_pkg::IRQ_W];
      end
      if (wr && hit_rl8) begin
        rl8_reg <= pwdata[15:0];
      end
      if (wr && hit_rl16) begin
        rl16_reg <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt8_reg <= 8'h00;
      cnt16_reg <= 16'h0000;
      out8_reg <= 1'b0;
      out16_reg <= 1'b0;
      dm_reg <= dct_pkg::DM_WAIT;
      pin_reg <= '0;
    end else begin
      cnt8_reg <= cnt8_next;
      cnt16_reg <= cnt16_next;
      out8_reg <= out8_next;
      out16_reg <= out16_next;
      dm_reg <= dm_next;
      pin_reg <= pin_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_cap_reg <= 8'h00;
      neg_cap_reg <= 8'h00;
    end else begin
      if (cap_pos) begin
        pos_cap_reg <= ~cnt8_reg;
      end
      if (cap_neg) begin
        neg_cap_reg <= ~cnt8_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= rd_mux;
      err_reg <= ~hit_any;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence dm_reach_zero;
    dm_counting && go8 && !cap_any && cnt8_reg == 8'h01;
  endsequence

  sequence dm_zero_then_wrap;
    c8_reg.timeout && cnt8_reg == 8'h00;
  endsequence

  no_wrap_timeout_a: assert property (
    (go8 && cnt8_reg == 8'h00) |-> !to8_ev)
    else $error("Wrap from zero flagged as timeout");

  run_on_tick_a: assert property (
    $rose(run8_reg) |-> $past(tick) && $past(c8_reg.en))
    else $error("Timer started without a counter clock tick");

  demod_start_a: assert property (
    (c8_reg.demod && dm_reg == dct_pkg::DM_WAIT && live8 && qual && !start8)
    |=> dm_reg == dct_pkg::DM_COUNT)
    else $error("First edge did not start demodulation count");

  capture_value_a: assert property (
    cap_pos |=> pos_cap_reg == ~$past(cnt8_reg))
    else $error("Positive capture not the complemented count");

  capture_flag_a: assert property (
    cap_neg |=> sh_reg.neg_flag && ist_reg[dct_pkg::IRQ_NEG])
    else $error("Negative edge flag not set after capture");

  capture_reload_a: assert property (
    (cap_any && !start8) |=> cnt8_reg == dct_pkg::ALL_ONES8)
    else $error("Timer not reloaded with all ones on capture");

  demod_timeout_a: assert property (
    (dm_reach_zero and !start8) |=> dm_zero_then_wrap)
    else $error("Demodulation zero did not set timeout");

  restart_load_a: assert property (
    start16 |=> cnt16_reg == $past(rl16_reg))
    else $error("Restart did not reload the initial value");

  pingpong_swap_a: assert property (
    (pp_on && to8_ev && !(wr && (hit_c8 || hit_c16)))
    |=> c16_reg.en && !c8_reg.en)
    else $error("Ping-pong did not hand over to sixteen-bit timer");

  pin_follow_a: assert property (
    c16_reg.out_en |=> port3_bit_five_oe && port3_bit_five == $past(out16_reg))
    else $error("Port3 bit five does not follow timer output");

endmodule // dct_core

// ### core/dct_pkg.sv
package dct_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL8 = 8'h00;
  localparam logic [7:0] OFF_SHARED = 8'h04;
  localparam logic [7:0] OFF_CTRL16 = 8'h08;
  localparam logic [7:0] OFF_RELOAD8 = 8'h0c;
  localparam logic [7:0] OFF_RELOAD16 = 8'h10;
  localparam logic [7:0] OFF_CAPTURE = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  localparam logic [7:0] OFF_ISTAT = 8'h1c;
  localparam logic [7:0] OFF_IMASK = 8'h20;

  // Field positions used for write-one-to-clear
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_POS_FLAG = 1;
  localparam int BIT_NEG_FLAG = 0;

  // Interrupt status bit positions, and the global enable bit in the mask register
  localparam int IRQ_TO8 = 0;
  localparam int IRQ_TO16 = 1;
  localparam int IRQ_POS = 2;
  localparam int IRQ_NEG = 3;
  localparam int IRQ_W = 4;

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [3:0] RST_IRQ = 4'h0;

  // Timing: counter/timer clock is pclk divided by TICK_DIV
  localparam int unsigned PCLK_MHZ = 200;
  localparam int unsigned TCLK_MHZ = 50;
  localparam int unsigned TICK_DIV = PCLK_MHZ / TCLK_MHZ;
  localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

  localparam logic [7:0] ALL_ONES8 = 8'hff;
  localparam logic [1:0] PP_ON = 2'h1;
  localparam logic [1:0] SEL_RISE = 2'h0;
  localparam logic [1:0] SEL_FALL = 2'h1;
  localparam logic [1:0] SEL_XNOR = 2'h2;

  typedef struct packed {
    logic en;
    logic single;
    logic timeout;
    logic demod;
    logic rsvd;
    logic cap_ie;
    logic to_ie;
    logic out_en;
  } dct_ctl_s;

  typedef struct packed {
    logic       rsvd;
    logic       comb_en;
    logic [1:0] sel;
    logic [1:0] pp;
    logic       pos_flag;
    logic       neg_flag;
  } dct_shr_s;

  typedef struct packed {
    logic p4;
    logic p5;
    logic p6;
    logic oe4;
    logic oe5;
    logic oe6;
  } dct_pin_s;

  typedef enum logic [0:0] {
    DM_WAIT  = 1'b0,
    DM_COUNT = 1'b1
  } dct_dm_e;

endpackage

// ### tb/dct_core_test.sv
`timescale 1ns/100ps
`define CHK(nm, ex, ac) \
  begin \
    compares++; \
    if ((ac) !== (ex)) begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", nm, ex, ac); \
    end \
  end
module dct_core_test;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              pready;
  logic              pslverr;
  logic              serr;
  logic              edge_in;
  logic              irq;
  logic              p4;
  logic              p4_oe;
  logic              p5;
  logic              p5_oe;
  logic              p6;
  logic              p6_oe;
  logic              ex;
  logic [7:0]        pcap;
  dct_pkg::dct_pin_s pins;
  int                bad_count;
  int                compares;
  int                cyc;

  dct_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .edge_in(edge_in), .irq(irq), .port3_bit_four(p4),
    .port3_bit_four_oe(p4_oe), .port3_bit_five(p5),
    .port3_bit_five_oe(p5_oe), .port3_bit_six(p6),
    .port3_bit_six_oe(p6_oe));

  dct_pins_model m (.pclk(pclk), .p4(p4), .p5(p5), .p6(p6), .oe4(p4_oe),
    .oe5(p5_oe), .oe6(p6_oe), .edge_in(edge_in), .pins(pins));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, rd)
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0000_0000);
    while (rd[b] !== v && n < 400) begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end
  endtask

  // Start demodulation, then three toggles of the edge input
  task automatic cap_run(input logic [1:0] sel);
    wr(dct_pkg::OFF_SHARED, {26'h0, sel, 4'h0});
    wr(dct_pkg::OFF_CTRL8, 32'h0000_0094);
    repeat (12) @(posedge pclk);
    m.set_level(~edge_in, 8);
    m.set_level(~edge_in, 40);
    m.set_level(~edge_in, 2);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl8", dct_pkg::OFF_CTRL8, 32'h0000_0000);
    rdc("shared", dct_pkg::OFF_SHARED, 32'h0000_0000);
    rdc("istat", dct_pkg::OFF_ISTAT, 32'h0000_0000);
    rdc("unmapped", 8'h40, 32'h0000_0000);
    `CHK("slverr", 1'b1, serr)
    `CHK("pready", 1'b1, pready)
    wr(dct_pkg::OFF_CTRL16, 32'h0000_001c);
    rdc("ctrl16_rsvd", dct_pkg::OFF_CTRL16, 32'h0000_0000);
    $display("test reset done");

    wr(dct_pkg::OFF_RELOAD8, 32'h0000_0505);
    for (int i = 0; i < 2; i++) begin
      wr(dct_pkg::OFF_CTRL8, 32'h0000_0080);
      apb(1'b0, dct_pkg::OFF_COUNT, 32'h0000_0000);
      if (i == 0) `CHK("cnt_early", 1'b1, rd[7:0] inside {8'h00, 8'h05})
      repeat (10) @(posedge pclk);
      apb(1'b0, dct_pkg::OFF_COUNT, 32'h0000_0000);
      `CHK("cnt_load", 1'b1, rd[7:0] inside {[2:3]})
      wr(dct_pkg::OFF_CTRL8, 32'h0000_0000);
      repeat (40) @(posedge pclk);
    end
    $display("test restart done");

    wr(dct_pkg::OFF_CTRL8, 32'h0000_0001);
    wr(dct_pkg::OFF_CTRL16, 32'h0000_0001);
    for (int s = 0; s < 4; s++) begin
      wr(dct_pkg::OFF_SHARED, 32'h0000_0040 | (s << 4));
      repeat (3) @(posedge pclk);
      `CHK("oe4", 1'b1, pins.oe4)
      `CHK("oe5", 1'b1, pins.oe5)
      `CHK("oe6", 1'b1, pins.oe6)
      case (s)
        0: ex = pins.p4 & pins.p5;
        1: ex = pins.p4 | pins.p5;
        2: ex = pins.p4 ~^ pins.p5;
        default: ex = pins.p4 ^ pins.p5;
      endcase
      `CHK("comb", ex, pins.p6)
    end
    wr(dct_pkg::OFF_CTRL8, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    `CHK("oe4_off", 1'b0, pins.oe4)
    $display("test pins done");

    wr(dct_pkg::OFF_RELOAD8, 32'h0000_ffff);
    for (int k = 0; k < 2; k++) begin
      wr(dct_pkg::OFF_IMASK, 32'h0000_0010 | (32'h0000_0004 << k));
      cap_run(k[1:0]);
      apb(1'b0, dct_pkg::OFF_COUNT, 32'h0000_0000);
      `CHK("reload_ff", 1'b1, rd[7:0] inside {[8'hfd:8'hff]})
      apb(1'b0, dct_pkg::OFF_CAPTURE, 32'h0000_0000);
      `CHK("cap", 1'b1, rd[k*8+:8] inside {[8'h09:8'h0f]})
      `CHK("cap_other", k ? pcap : 8'h00, rd[(1-k)*8+:8])
      pcap = rd[7:0];
      apb(1'b0, dct_pkg::OFF_SHARED, 32'h0000_0000);
      `CHK("flags", 2'b10 >> k, rd[1:0])
      rdc("istat", dct_pkg::OFF_ISTAT, 32'h0000_0004 << k);
      `CHK("irq_on", 1'b1, irq)
      wr(dct_pkg::OFF_IMASK, 32'h0000_0010);
      @(posedge pclk);
      `CHK("irq_mask", 1'b0, irq)
      wr(dct_pkg::OFF_IMASK, 32'h0000_0004 << k);
      @(posedge pclk);
      `CHK("irq_global", 1'b0, irq)
      wr(dct_pkg::OFF_CTRL8, 32'h0000_0000);
      wr(dct_pkg::OFF_ISTAT, 32'h0000_000f);
      wr(dct_pkg::OFF_SHARED, 32'h0000_0003 | (k << 4));
      rdc("istat_clr", dct_pkg::OFF_ISTAT, 32'h0000_0000);
      rdc("flag_clr", dct_pkg::OFF_SHARED, k << 4);
    end
    $display("test demod done");

    wr(dct_pkg::OFF_IMASK, 32'h0000_0011);
    wr(dct_pkg::OFF_SHARED, 32'h0000_0000);
    wr(dct_pkg::OFF_CTRL8, 32'h0000_0092);
    repeat (12) @(posedge pclk);
    m.set_level(~edge_in, 2);
    poll(dct_pkg::OFF_CTRL8, dct_pkg::BIT_TIMEOUT, 1'b1);
    `CHK("timeout", 1'b1, rd[5])
    `CHK("irq_to", 1'b1, irq)
    wr(dct_pkg::OFF_CTRL8, 32'h0000_00b2);
    repeat (30) @(posedge pclk);
    rdc("no_wrap_to", dct_pkg::OFF_CTRL8, 32'h0000_0092);
    wr(dct_pkg::OFF_CTRL8, 32'h0000_0000);
    wr(dct_pkg::OFF_ISTAT, 32'h0000_000f);
    $display("test timeout done");

    wr(dct_pkg::OFF_RELOAD8, 32'h0000_0303);
    wr(dct_pkg::OFF_RELOAD16, 32'h0000_0003);
    wr(dct_pkg::OFF_CTRL16, 32'h0000_0040);
    wr(dct_pkg::OFF_SHARED, 32'h0000_0004);
    wr(dct_pkg::OFF_CTRL8, 32'h0000_0040);
    wr(dct_pkg::OFF_CTRL8, 32'h0000_00c0);
    poll(dct_pkg::OFF_CTRL16, 7, 1'b1);
    `CHK("pp16_on", 1'b1, rd[7])
    apb(1'b0, dct_pkg::OFF_CTRL8, 32'h0000_0000);
    `CHK("pp8_off", 2'b01, {rd[7], rd[5]})
    poll(dct_pkg::OFF_CTRL8, 7, 1'b1);
    `CHK("pp8_on", 1'b1, rd[7])
    apb(1'b0, dct_pkg::OFF_CTRL16, 32'h0000_0000);
    `CHK("pp16_off", 2'b01, {rd[7], rd[5]})
    $display("test pingpong done");
    report_and_stop();
  end
endmodule // dct_core_test

// ### tb/dct_pins_model.sv
`timescale 1ns/100ps
module dct_pins_model (
  input  wire logic         pclk,
  input  wire logic         p4,
  input  wire logic         p5,
  input  wire logic         p6,
  input  wire logic         oe4,
  input  wire logic         oe5,
  input  wire logic         oe6,
  output logic              edge_in,
  output dct_pkg::dct_pin_s pins
);
  // Undriven pins float high through pull-ups
  assign pins = '{p4: oe4 ? p4 : 1'b1, p5: oe5 ? p5 : 1'b1,
                  p6: oe6 ? p6 : 1'b1, oe4: oe4, oe5: oe5, oe6: oe6};

  initial edge_in = 1'b0;

  // One level change on the edge input, then hold
  task automatic set_level(input logic lvl, input int hold);
    @(posedge pclk);
    edge_in <= lvl;
    repeat (hold) @(posedge pclk);
  endtask
endmodule // dct_pins_model
